// ===== logic/ossf_pkg.sv
/*
 * Shared constants for the optical sample sequence queue: register
 * offsets, field positions, reset values, tags, slot codes and states.
 * Assumes the serial port carries 7-bit register offsets.
 */
package ossf_pkg;
	// register offsets
	localparam logic [6:0] ADDR_WR_IDX = 7'h04;
	localparam logic [6:0] ADDR_RD_IDX = 7'h05;
	localparam logic [6:0] ADDR_LOST = 7'h06;
	localparam logic [6:0] ADDR_COUNT = 7'h07;
	localparam logic [6:0] ADDR_PORT = 7'h08;
	localparam logic [6:0] ADDR_WMARK = 7'h09;
	localparam logic [6:0] ADDR_CTL = 7'h0a;
	localparam logic [6:0] ADDR_SLOT12 = 7'h20;
	localparam logic [6:0] ADDR_SLOT34 = 7'h21;
	localparam logic [6:0] ADDR_SLOT56 = 7'h22;
	// reset values
	localparam logic [7:0] SLOTS_RST = 8'h00;
	localparam logic [6:0] WMARK_RST = 7'h00;
	localparam logic [7:0] CTL_RST = 8'h00;
	// control register fields
	localparam int CTL_TS_EN = 5;
	localparam int CTL_FLUSH = 4;
	localparam int CTL_STAT_CLR = 3;
	localparam int CTL_AFULL_TYPE = 2;
	localparam int CTL_PUSH_FULL = 1;
	// item layout: tag above a left-justified value
	localparam int TAG_MSB = 23;
	localparam int TAG_LSB = 19;
	localparam logic [4:0] TAG_SLOT1 = 5'h01;
	localparam logic [4:0] TAG_FENCE1 = 5'h0d;
	localparam logic [4:0] TAG_PROX = 5'h19;
	localparam logic [4:0] TAG_INVALID = 5'h1e;
	localparam logic [4:0] TAG_STAMP = 5'h1f;
	// slot codes
	localparam logic [3:0] CODE_NONE = 4'h0;
	localparam logic [3:0] CODE_PILOT = 4'h8;
	localparam logic [3:0] CODE_AMBIENT = 4'h9;
	localparam logic [3:0] CODE_EMIT4 = 4'ha;
	localparam logic [3:0] CODE_EMIT6 = 4'hc;
	localparam logic [2:0] LAST_SLOT = 3'h5;
	localparam logic [2:0] FENCE_SLOTS = 3'h3;
	// queue geometry
	localparam logic [7:0] QUEUE_DEPTH = 8'h80;
	localparam logic [6:0] IDX_MAX = 7'h7f;
	localparam logic [6:0] LOST_MAX = 7'h7f;
	localparam logic [1:0] ITEM_BYTES = 2'h3;
	typedef enum logic [1:0] {
		OSSF_IDLE = 2'b00,
		OSSF_EXPOSE = 2'b01,
		OSSF_WAIT = 2'b11,
		OSSF_STAMP = 2'b10
	} ossf_state_t;
endpackage : ossf_pkg

// ===== logic/ossf_core.sv
/*
 * Exposure sequencer and tagged 128-item sample queue with its serial
 * register port. Assumes sample_tick and the conversion handshake come
 * from logic on clk; the serial port is mode 0 on its own clock sclk.
 */
// How it works
// - each sample period walks slots one to six in order.
// - first slot holding code zero ends the period's sequence.
// - codes 1-7 drive emitter sets, 8 pilot on one, 9 ambient.
// - codes a-c pick external emitters four to six; d-f unused.
// - three slot registers, odd slot low nibble, reset zero.
// - normal result of slot n carries tag n.
// - fence result in slots one to three uses tags 0d to 0f.
// - pilot in slot one gives proximity tag 19.
// - reading an empty queue returns tag 1e.
// - with timestamps enabled a tag 1f timestamp item is pushed.
// - item is tag in bits 23:19 over 19-bit value.
// - write index names next slot, steps once per stored push.
// - write index is 7 bits, wraps 7f to 00.
// - read index steps per whole item read, wraps 7f to 00.
// - host may write read index to rewind.
// - control register holds stamp, clear, type, overwrite; flush not held.
// - watermark 7 bits; item count full 8 bits.
// - three-byte burst at the read port pops one item.
// - full queue overwrites oldest if selected, else drops new.
// - lost counter counts drops and overwrites, saturates 7f, clears on pop.
module ossf_core (
	// system
	input wire logic clk,
	input wire logic arst_n,
	// serial register port
	input wire logic sclk,
	input wire logic csb_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	// conversion side
	input wire logic sample_tick,
	input wire logic conv_valid,
	input wire logic [18:0] conv_value,
	input wire logic conv_fence,
	// exposure control
	output logic expose_strobe,
	output logic [2:0] led_drive,
	output logic pilot_exposure,
	output logic ambient_sample,
	output logic [1:0] ext_emitter_sel
);
	function automatic logic [3:0] slot_code(input logic [23:0] s,
		input logic [2:0] i);
		slot_code = s[{i, 2'b00} +: 4];
	endfunction : slot_code

	// {pilot, ambient, ext_sel[1:0], led[2:0]}
	function automatic logic [6:0] decode(input logic [3:0] c);
		case (c)
		4'h1: decode = 7'h01;
		4'h2: decode = 7'h02;
		4'h3: decode = 7'h04;
		4'h4: decode = 7'h03;
		4'h5: decode = 7'h05;
		4'h6: decode = 7'h06;
		4'h7: decode = 7'h07;
		ossf_pkg::CODE_PILOT: decode = 7'h41;
		ossf_pkg::CODE_AMBIENT: decode = 7'h20;
		ossf_pkg::CODE_EMIT4: decode = 7'h08;
		4'hb: decode = 7'h10;
		ossf_pkg::CODE_EMIT6: decode = 7'h18;
		default: decode = 7'h00;
		endcase
	endfunction : decode

	function automatic logic [4:0] tag_of(input logic [3:0] c,
		input logic [2:0] i, input logic fence);
		if (i == 3'h0 && c == ossf_pkg::CODE_PILOT)
			tag_of = ossf_pkg::TAG_PROX;
		else if (fence && i < ossf_pkg::FENCE_SLOTS)
			tag_of = ossf_pkg::TAG_FENCE1 + {2'h0, i};
		else
			tag_of = ossf_pkg::TAG_SLOT1 + {2'h0, i};
	endfunction : tag_of

	// serial side, sclk domain
	logic [2:0] bit_cnt_ff;
	logic [1:0] byte_cnt_ff;
	logic [6:0] shin_ff, addr_ff;
	logic [7:0] wdat_ff;
	logic rd_ff, wr_vld_ff, pop_ff, frame_tog_ff, sdo_ff;
	// clk domain
	logic csb_s1_ff, csb_s2_ff, tog_s1_ff, tog_s2_ff, tog_seen_ff, strobe_ff;
	logic [6:0] wr_idx_ff, rd_idx_ff, lost_ff, wmark_ff;
	logic [7:0] count_ff, ctl_ff, snap_cnt_ff;
	logic [7:0] slots12_ff, slots34_ff, slots56_ff;
	logic [23:0] mem_ff [128];
	logic [6:0] snap_wr_ff, snap_rd_ff, snap_lost_ff;
	logic [23:0] snap_item_ff;
	logic [18:0] stamp_ff;
	logic [2:0] slot_ff, nxt_slot;
	ossf_pkg::ossf_state_t state_ff, nxt_state;
	logic [6:0] drive_ff, nxt_drive;

	wire [7:0] rx_byte = {shin_ff, sdi};
	wire byte_done = bit_cnt_ff == 3'h7;
	wire first_edge = bit_cnt_ff == 3'h0 && byte_cnt_ff == 2'h0;
	wire [23:0] slots = {slots56_ff, slots34_ff, slots12_ff};
	wire ts_en = ctl_ff[ossf_pkg::CTL_TS_EN];

	// read data, frozen snapshot or static config during a frame
	wire [7:0] item_byte = byte_cnt_ff == 2'h1 ? snap_item_ff[23:16] :
		byte_cnt_ff == 2'h2 ? snap_item_ff[15:8] : snap_item_ff[7:0];
	wire [7:0] rd_byte =
		addr_ff == ossf_pkg::ADDR_WR_IDX ? {1'b0, snap_wr_ff} :
		addr_ff == ossf_pkg::ADDR_RD_IDX ? {1'b0, snap_rd_ff} :
		addr_ff == ossf_pkg::ADDR_LOST ? {1'b0, snap_lost_ff} :
		addr_ff == ossf_pkg::ADDR_COUNT ? snap_cnt_ff :
		addr_ff == ossf_pkg::ADDR_PORT ? item_byte :
		addr_ff == ossf_pkg::ADDR_WMARK ? {1'b0, wmark_ff} :
		addr_ff == ossf_pkg::ADDR_CTL ? ctl_ff :
		addr_ff == ossf_pkg::ADDR_SLOT12 ? slots12_ff :
		addr_ff == ossf_pkg::ADDR_SLOT34 ? slots34_ff :
		addr_ff == ossf_pkg::ADDR_SLOT56 ? slots56_ff : 8'h00;

	// bit and byte position, cleared while deselected
	always_ff @(posedge sclk or posedge csb_n) begin
		if (csb_n) begin
			bit_cnt_ff <= 3'h0;
			byte_cnt_ff <= 2'h0;
		end else begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			if (byte_done && byte_cnt_ff != ossf_pkg::ITEM_BYTES)
				byte_cnt_ff <= byte_cnt_ff + 2'h1;
		end
	end

	// frame results outlive the frame so clk can pick them up after it
	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			shin_ff <= 7'h00;
			addr_ff <= 7'h00;
			rd_ff <= 1'b0;
			wdat_ff <= 8'h00;
			wr_vld_ff <= 1'b0;
			pop_ff <= 1'b0;
			frame_tog_ff <= 1'b0;
		end else begin
			shin_ff <= rx_byte[6:0];
			if (first_edge) begin
				frame_tog_ff <= ~frame_tog_ff;
				wr_vld_ff <= 1'b0;
				pop_ff <= 1'b0;
			end
			if (byte_done && byte_cnt_ff == 2'h0) begin
				rd_ff <= rx_byte[7];
				addr_ff <= rx_byte[6:0];
			end
			if (byte_done && byte_cnt_ff == 2'h1 && !rd_ff) begin
				wdat_ff <= rx_byte;
				wr_vld_ff <= 1'b1;
			end
			if (byte_done && byte_cnt_ff == ossf_pkg::ITEM_BYTES && rd_ff &&
				addr_ff == ossf_pkg::ADDR_PORT)
				pop_ff <= 1'b1;
		end
	end

	always_ff @(negedge sclk or negedge arst_n) begin
		if (!arst_n)
			sdo_ff <= 1'b0;
		else
			sdo_ff <= rd_byte[3'h7 - bit_cnt_ff];
	end
	assign sdo = sdo_ff;
	assign sdo_oe = ~csb_n;

	// crossing: frame toggle as event, its data held stable meanwhile
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			csb_s1_ff <= 1'b1;
			csb_s2_ff <= 1'b1;
			tog_s1_ff <= 1'b0;
			tog_s2_ff <= 1'b0;
			tog_seen_ff <= 1'b0;
		end else begin
			csb_s1_ff <= csb_n;
			csb_s2_ff <= csb_s1_ff;
			tog_s1_ff <= frame_tog_ff;
			tog_s2_ff <= tog_s1_ff;
			if (csb_s2_ff)
				tog_seen_ff <= tog_s2_ff;
		end
	end
	wire apply = csb_s2_ff && tog_s2_ff != tog_seen_ff;
	wire wr_en = apply && wr_vld_ff;
	// pop only what the frame saw; a push during the frame is not eaten
	wire do_pop = apply && pop_ff && snap_cnt_ff != 8'h00;
	wire flush = wr_en && addr_ff == ossf_pkg::ADDR_CTL &&
		wdat_ff[ossf_pkg::CTL_FLUSH];
	wire rd_write = wr_en && addr_ff == ossf_pkg::ADDR_RD_IDX;

	// sequencer
	wire [3:0] cur_code = slot_code(slots, slot_ff);
	wire [3:0] next_code = slot_code(slots, slot_ff + 3'h1);
	wire seq_last = slot_ff == ossf_pkg::LAST_SLOT ||
		next_code == ossf_pkg::CODE_NONE;
	wire push = (state_ff == ossf_pkg::OSSF_WAIT && conv_valid) ||
		state_ff == ossf_pkg::OSSF_STAMP;
	wire [23:0] push_item = state_ff == ossf_pkg::OSSF_STAMP ?
		{ossf_pkg::TAG_STAMP, stamp_ff} :
		{tag_of(cur_code, slot_ff, conv_fence), conv_value};

	always_comb begin
		nxt_state = state_ff;
		nxt_slot = slot_ff;
		case (state_ff)
		ossf_pkg::OSSF_IDLE: begin
			if (sample_tick) begin
				nxt_slot = 3'h0;
				if (slot_code(slots, 3'h0) != ossf_pkg::CODE_NONE)
					nxt_state = ossf_pkg::OSSF_EXPOSE;
				else if (ts_en)
					nxt_state = ossf_pkg::OSSF_STAMP;
			end
		end
		ossf_pkg::OSSF_EXPOSE: nxt_state = ossf_pkg::OSSF_WAIT;
		ossf_pkg::OSSF_WAIT: begin
			if (conv_valid && seq_last) begin
				nxt_state = ts_en ? ossf_pkg::OSSF_STAMP :
					ossf_pkg::OSSF_IDLE;
			end else if (conv_valid) begin
				nxt_state = ossf_pkg::OSSF_EXPOSE;
				nxt_slot = slot_ff + 3'h1;
			end
		end
		ossf_pkg::OSSF_STAMP: nxt_state = ossf_pkg::OSSF_IDLE;
		default: nxt_state = ossf_pkg::OSSF_IDLE;
		endcase
	end
	assign nxt_drive = nxt_state == ossf_pkg::OSSF_EXPOSE ?
		decode(slot_code(slots, nxt_slot)) : 7'h00;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ossf_pkg::OSSF_IDLE;
			slot_ff <= 3'h0;
			drive_ff <= 7'h00;
			strobe_ff <= 1'b0;
			stamp_ff <= 19'h00000;
		end else begin
			state_ff <= nxt_state;
			slot_ff <= nxt_slot;
			drive_ff <= nxt_drive;
			strobe_ff <= nxt_state == ossf_pkg::OSSF_EXPOSE;
			if (sample_tick)
				stamp_ff <= stamp_ff + 19'h00001;
		end
	end
	assign expose_strobe = strobe_ff;
	assign led_drive = drive_ff[2:0];
	assign ext_emitter_sel = drive_ff[4:3];
	assign ambient_sample = drive_ff[5];
	assign pilot_exposure = drive_ff[6];

	// queue
	wire full = count_ff == ossf_pkg::QUEUE_DEPTH;
	wire push_full_sel = ctl_ff[ossf_pkg::CTL_PUSH_FULL];
	wire lost_evt = push && full && !do_pop;
	wire store = push && (!full || do_pop || push_full_sel);
	wire overwrite = lost_evt && push_full_sel;
	wire [6:0] lost_inc = lost_ff == ossf_pkg::LOST_MAX ? lost_ff :
		lost_ff + 7'h01;

	always_ff @(posedge clk) begin
		if (store && !flush)
			mem_ff[wr_idx_ff] <= push_item;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_idx_ff <= 7'h00;
			rd_idx_ff <= 7'h00;
			count_ff <= 8'h00;
			lost_ff <= 7'h00;
		end else if (flush) begin
			wr_idx_ff <= 7'h00;
			rd_idx_ff <= 7'h00;
			count_ff <= 8'h00;
			lost_ff <= 7'h00;
		end else begin
			if (store)
				wr_idx_ff <= wr_idx_ff + 7'h01;
			if (rd_write)
				rd_idx_ff <= wdat_ff[6:0];
			else if (do_pop || overwrite)
				rd_idx_ff <= rd_idx_ff + 7'h01;
			if (rd_write)
				count_ff <= {1'b0, wr_idx_ff - wdat_ff[6:0]};
			else
				count_ff <= count_ff + {7'h00, store} - {7'h00, do_pop} -
					{7'h00, overwrite};
			if (do_pop)
				lost_ff <= {6'h00, lost_evt};
			else if (lost_evt)
				lost_ff <= lost_inc;
		end
	end

	// config registers, written when a frame is applied
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slots12_ff <= ossf_pkg::SLOTS_RST;
			slots34_ff <= ossf_pkg::SLOTS_RST;
			slots56_ff <= ossf_pkg::SLOTS_RST;
			wmark_ff <= ossf_pkg::WMARK_RST;
			ctl_ff <= ossf_pkg::CTL_RST;
		end else if (wr_en) begin
			if (addr_ff == ossf_pkg::ADDR_SLOT12)
				slots12_ff <= wdat_ff;
			if (addr_ff == ossf_pkg::ADDR_SLOT34)
				slots34_ff <= wdat_ff;
			if (addr_ff == ossf_pkg::ADDR_SLOT56)
				slots56_ff <= wdat_ff;
			if (addr_ff == ossf_pkg::ADDR_WMARK)
				wmark_ff <= wdat_ff[6:0];
			if (addr_ff == ossf_pkg::ADDR_CTL)
				ctl_ff <= wdat_ff & 8'h2e;
		end
	end

	// snapshot frozen while selected so a frame reads one coherent view
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			snap_wr_ff <= 7'h00;
			snap_rd_ff <= 7'h00;
			snap_lost_ff <= 7'h00;
			snap_cnt_ff <= 8'h00;
			snap_item_ff <= 24'h000000;
		end else if (csb_s2_ff) begin
			snap_wr_ff <= wr_idx_ff;
			snap_rd_ff <= rd_idx_ff;
			snap_lost_ff <= lost_ff;
			snap_cnt_ff <= count_ff;
			snap_item_ff <= count_ff == 8'h00 ?
				{ossf_pkg::TAG_INVALID, 19'h00000} : mem_ff[rd_idx_ff];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_wr_idx_step: assert property (store && !flush |=>
		wr_idx_ff == $past(wr_idx_ff) + 7'h01)
		else $error("write index did not step on push");
	a_wr_idx_wrap: assert property (store && !flush &&
		wr_idx_ff == ossf_pkg::IDX_MAX |=> wr_idx_ff == 7'h00)
		else $error("write index did not wrap");
	a_pop_moves_rd: assert property (do_pop |=>
		rd_idx_ff == $past(rd_idx_ff) + 7'h01 && lost_ff <= 7'h01)
		else $error("pop did not advance read index");
	a_drop_holds: assert property (push && full && !push_full_sel &&
		!do_pop && !apply |=> $stable(wr_idx_ff) && $stable(count_ff))
		else $error("full queue changed on dropped sample");
	a_lost_bound: assert property (lost_evt && !apply &&
		lost_ff == ossf_pkg::LOST_MAX |=> lost_ff == ossf_pkg::LOST_MAX)
		else $error("lost counter did not saturate");
	a_slot_order: assert property (state_ff == ossf_pkg::OSSF_WAIT &&
		conv_valid && !seq_last |=> expose_strobe &&
		slot_ff == $past(slot_ff) + 3'h1)
		else $error("next slot not exposed in order");
	a_zero_ends: assert property (expose_strobe |->
		cur_code != ossf_pkg::CODE_NONE ##1 !expose_strobe)
		else $error("zero slot exposed");
	a_tag_normal: assert property (state_ff == ossf_pkg::OSSF_WAIT &&
		conv_valid && !conv_fence && cur_code != ossf_pkg::CODE_PILOT |->
		push_item[23:19] == ossf_pkg::TAG_SLOT1 + {2'h0, slot_ff})
		else $error("wrong slot tag");
	a_tag_fence: assert property (state_ff == ossf_pkg::OSSF_WAIT &&
		conv_valid && conv_fence && slot_ff != 3'h0 && slot_ff < 3'h3 |->
		push_item[23:19] == ossf_pkg::TAG_FENCE1 + {2'h0, slot_ff})
		else $error("wrong fence tag");
	a_tag_prox: assert property (state_ff == ossf_pkg::OSSF_WAIT &&
		conv_valid && slot_ff == 3'h0 && cur_code == ossf_pkg::CODE_PILOT
		|-> push_item[23:19] == ossf_pkg::TAG_PROX)
		else $error("pilot result not tagged proximity");
	a_empty_read: assert property (csb_s2_ff && count_ff == 8'h00 |=>
		snap_item_ff[23:19] == ossf_pkg::TAG_INVALID)
		else $error("empty queue not reported invalid");
	a_stamp_item: assert property (state_ff == ossf_pkg::OSSF_STAMP |->
		ts_en && push_item[23:19] == ossf_pkg::TAG_STAMP ##1
		state_ff == ossf_pkg::OSSF_IDLE)
		else $error("timestamp item malformed");

	c_full_period: cover property (state_ff == ossf_pkg::OSSF_WAIT &&
		conv_valid && slot_ff == ossf_pkg::LAST_SLOT);
	c_overwrite: cover property (overwrite);
	c_pop_item: cover property (do_pop ##[1:20] do_pop);
	c_stamp: cover property (state_ff == ossf_pkg::OSSF_STAMP);
endmodule : ossf_core

// ===== tb/ossf_host.sv
/*
 * Host model for the sample queue: issues serial frames in mode 0.
 * Assumes the bench calls frame() one at a time and nothing else
 * drives the serial lines.
 */
module ossf_host (
	// serial lines
	output logic sclk,
	output logic csb_n,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// cleared if the output enable ever drops inside a frame
	logic oe_ok = 1'b1;

	initial begin
		sclk = 1'b0;
		csb_n = 1'b1;
		sdi = 1'b0;
	end

	// command byte, then nb data bytes; returned bits shift into rd
	task automatic frame(input logic [7:0] cmd, input logic [7:0] wd,
		input int nb, output logic [23:0] rd);
		logic [7:0] b;
		rd = 24'h0;
		#1.3 csb_n = 1'b0;
		#100;
		for (int i = 0; i <= nb; i++) begin
			b = (i == 0) ? cmd : wd;
			for (int j = 7; j >= 0; j--) begin
				sdi = b[j];
				#3 sclk = 1'b1;
				rd = {rd[22:0], sdo};
				if (sdo_oe !== 1'b1)
					oe_ok = 1'b0;
				#3 sclk = 1'b0;
			end
		end
		// whole burst done before release, so a pop is earned
		#3 csb_n = 1'b1;
		// idle data line must not keep echoing the last bit
		sdi = ~sdi;
		#200;
	endtask : frame
endmodule : ossf_host

// ===== tb/optical_sample_sequence_fifo_tb.sv
/*
 * Self-checking bench for the sequencer and tagged sample queue.
 * Assumes ossf_core as declared and the host model ossf_host; the
 * bench plays the conversion side and keeps a model of the queue.
 */
module optical_sample_sequence_fifo_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic arst_n, sample_tick, conv_valid, conv_fence;
	logic [18:0] conv_value;
	wire logic sclk, csb_n, sdi, sdo, sdo_oe, expose_strobe;
	wire logic pilot_exposure, ambient_sample;
	wire logic [2:0] led_drive;
	wire logic [1:0] ext_emitter_sel;
	int num_errors = 0;
	int checks = 0;
	int mcnt = 0;
	int nticks = 0;
	logic [31:0] seed = 32'h49;
	logic [23:0] mem [128];
	logic stp [128];
	logic [6:0] mwr = 7'h0, mrd = 7'h0, mlost = 7'h0, d7;
	logic [3:0] sl [6];
	logic ro = 1'b0, tsen = 1'b0;
	logic [23:0] junk;
	logic [23:0] cfgs [6] = '{24'h000201, 24'h0, 24'h654321, 24'hcba987,
		24'h0000c8, 24'h070000};
	logic [6:0] regs [10] = '{7'h04, 7'h05, 7'h06, 7'h07, 7'h09, 7'h0a,
		7'h20, 7'h21, 7'h22, 7'h3f};

	always #12.5 clk = ~clk;

	ossf_core ossf_core_i (.clk, .arst_n, .sclk, .csb_n, .sdi, .sdo,
		.sdo_oe, .sample_tick, .conv_valid, .conv_value, .conv_fence,
		.expose_strobe, .led_drive, .pilot_exposure, .ambient_sample,
		.ext_emitter_sel);
	ossf_host ossf_host_i (.sclk, .csb_n, .sdi, .sdo, .sdo_oe);

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	// {led_drive, pilot, ambient, emitter select}
	function automatic logic [6:0] exp_drv(input logic [3:0] c);
		case (c)
			4'h1: return 7'h10;
			4'h2: return 7'h20;
			4'h3: return 7'h40;
			4'h4: return 7'h30;
			4'h5: return 7'h50;
			4'h6: return 7'h60;
			4'h7: return 7'h70;
			4'h8: return 7'h18;
			4'h9: return 7'h04;
			4'ha: return 7'h01;
			4'hb: return 7'h02;
			4'hc: return 7'h03;
			default: return 7'h00;
		endcase
	endfunction : exp_drv

	function automatic logic [4:0] exp_tag(input int k, input logic [3:0] c,
		input logic f);
		if (k == 0 && c == 4'h8)
			return 5'h19;
		if (f && k < 3)
			return 5'h0d + 5'(k);
		return 5'h01 + 5'(k);
	endfunction : exp_tag

	function automatic logic [23:0] rcfg();
		logic [23:0] c;
		logic [31:0] r;
		for (int i = 0; i < 6; i++) begin
			r = rnd() % 13;
			c[4*i+:4] = r[3:0];
		end
		return c;
	endfunction : rcfg

	task automatic complete_run();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask : check

	task automatic wreg(input logic [6:0] a, input logic [7:0] d);
		ossf_host_i.frame({1'b0, a}, d, 1, junk);
	endtask : wreg

	task automatic chk_reg(input logic [6:0] a, input logic [7:0] e);
		logic [23:0] rd;
		ossf_host_i.frame({1'b1, a}, 8'h00, 1, rd);
		check(rd[7:0], e);
	endtask : chk_reg

	task automatic chk_idx();
		chk_reg(7'h04, {1'b0, mwr});
		chk_reg(7'h05, {1'b0, mrd});
		chk_reg(7'h06, {1'b0, mlost});
		chk_reg(7'h07, 8'(mcnt));
	endtask : chk_idx

	// model push: full queue drops or overwrites per the select bit
	task automatic mpush(input logic [23:0] it, input logic st);
		if (mcnt == 128 && !ro) begin
			if (mlost < 7'h7f)
				mlost++;
		end else begin
			mem[mwr] = it;
			stp[mwr] = st;
			mwr++;
			if (mcnt == 128) begin
				mrd++;
				if (mlost < 7'h7f)
					mlost++;
			end else
				mcnt++;
		end
	endtask : mpush

	task automatic pop();
		logic [23:0] rd;
		ossf_host_i.frame(8'h88, 8'h00, 3, rd);
		if (mcnt == 0)
			check(rd[23:19], 5'h1e);
		else begin
			if (stp[mrd])
				check(rd, mem[mrd]);
			else
				check(rd, mem[mrd]);
			mrd++;
			mcnt--;
			mlost = 7'h0;
		end
	endtask : pop

	task automatic drain();
		for (int g = 0; g < 130 && mcnt > 0; g++)
			pop();
		pop();
		chk_idx();
		check({ossf_host_i.oe_ok, sdo_oe}, 2'b10);
	endtask : drain

	task automatic setcfg(input logic [23:0] c);
		for (int i = 0; i < 6; i++)
			sl[i] = c[4*i+:4];
		for (int i = 0; i < 3; i++) begin
			wreg(7'h20 + 7'(i), c[8*i+:8]);
			chk_reg(7'h20 + 7'(i), c[8*i+:8]);
		end
	endtask : setcfg

	task automatic wctl(input logic t, input logic f, input logic [1:0] x,
		input logic o);
		logic [7:0] d;
		d = {2'b00, t, f, x, o, 1'b0};
		wreg(7'h0a, d);
		chk_reg(7'h0a, d & 8'hef);
		tsen = t;
		ro = o;
		if (f) begin
			mwr = 7'h0;
			mrd = 7'h0;
			mcnt = 0;
			mlost = 7'h0;
		end
	endtask : wctl

	// one sample period; the far side answers each strobe after 1..4 cycles
	task automatic period();
		int n, w, extra;
		logic [31:0] r;
		n = 0;
		while (n < 6 && sl[n] != 4'h0)
			n++;
		@(posedge clk) sample_tick <= 1'b1;
		@(posedge clk) sample_tick <= 1'b0;
		nticks++;
		for (int k = 0; k < n; k++) begin
			w = 0;
			#1;
			while (expose_strobe !== 1'b1 && w < 40) begin
				@(posedge clk);
				#1;
				w++;
			end
			if (w >= 40) begin
				num_errors++;
				complete_run();
			end
			check({pilot_exposure, ambient_sample, ext_emitter_sel},
				exp_drv(sl[k]) & 7'h0f);
			check(led_drive, exp_drv(sl[k]) >> 4);
			r = rnd();
			repeat (r[1:0] + 1) @(posedge clk);
			conv_valid <= 1'b1;
			conv_value <= r[26:8];
			conv_fence <= r[30];
			@(posedge clk) conv_valid <= 1'b0;
			mpush({exp_tag(k, sl[k], r[30]), r[26:8]}, 1'b0);
		end
		extra = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			if (expose_strobe === 1'b1)
				extra++;
		end
		check(extra, 0);
		if (tsen)
			mpush({5'h1f, 19'(nticks)}, 1'b1);
	endtask : period

	initial begin
		arst_n = 1'b0;
		sample_tick = 1'b0;
		conv_valid = 1'b0;
		conv_fence = 1'b0;
		conv_value = 19'h0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (regs[i])
			chk_reg(regs[i], 8'h00);
		// read-only index must ignore a write
		wreg(7'h04, 8'h55);
		drain();
		foreach (cfgs[i]) begin
			setcfg(cfgs[i]);
			period();
			drain();
		end
		for (int p = 0; p < 30; p++) begin
			wctl(seed[0], 1'b0, seed[2:1], 1'b0);
			setcfg(rcfg());
			period();
			if (seed[3])
				drain();
		end
		drain();
		// overfill with drop policy, lost counter saturates
		wctl(1'b0, 1'b0, 2'b00, 1'b0);
		setcfg(24'h654321);
		repeat (50) period();
		chk_idx();
		pop();
		pop();
		// rewind one item and read it again
		wreg(7'h05, {1'b0, mrd - 7'h1});
		mrd = mrd - 7'h1;
		d7 = mwr - mrd;
		mcnt = d7;
		pop();
		wctl(1'b1, 1'b0, 2'b11, 1'b1);
		repeat (4) period();
		chk_idx();
		drain();
		period();
		wctl(1'b0, 1'b1, 2'b00, 1'b0);
		chk_idx();
		complete_run();
	end
endmodule : optical_sample_sequence_fifo_tb
